//--- bench/ltep_ctl_model.sv
`timescale 1ns/100ps

module ltep_ctl_model (
    input wire logic pclk,
    input wire logic [4:0] want,
    output logic cooler_enable,
    output logic laser_enable,
    output logic switch_cooler,
    output logic switch_laser,
    output logic safety_lock_input
);
    // Pins follow the wanted levels one edge late, as a slow controller would
    always_ff @(posedge pclk) begin
        cooler_enable <= want[0];
        laser_enable <= want[1];
        switch_cooler <= want[2];
        switch_laser <= want[3];
        safety_lock_input <= want[4]; // Open interlock is a high level
    end
endmodule : ltep_ctl_model

//--- bench/tb.sv
`timescale 1ns/100ps

module tb import ltep_pkg::*;;
    localparam int SC = 20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic nv_clear_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [4:0] want = 5'b00010;
    logic cooler_enable, laser_enable, switch_cooler, switch_laser, safety_lock_input;
    logic [2:0] cflt = 3'h0;
    logic trip = 1'b0, j_cur = 1'b0, j_tmp = 1'b0, snap = 1'b0;
    logic [15:0] therm = 16'h0100, ilim;
    logic cooler_run, laser_drive, laser_softstart, cooler_fault, eoc, shunt, red, yellow;
    logic [1:0] cur_src, tmp_src;
    logic [2:0] ctl = 3'h0;
    logic [32:0] rdq[$];
    logic [27:0] pinq[$];
    logic [15:0] lim_e = 16'h07D0;
    int errors = 0, tests_run = 0, seed = 63;

    // Free-running bench clock
    always #5 pclk = ~pclk;

    ltep_ctl_model ltep_ctl_model_i (.pclk(pclk), .want(want), .cooler_enable(cooler_enable),
        .laser_enable(laser_enable), .switch_cooler(switch_cooler),
        .switch_laser(switch_laser), .safety_lock_input(safety_lock_input));

    ltep_top #(.SOFT_CYC(SC), .TW(16)) ltep_top_i (.pclk(pclk), .presetn(presetn),
        .nv_clear_n(nv_clear_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cooler_enable(cooler_enable), .laser_enable(laser_enable),
        .switch_cooler(switch_cooler), .switch_laser(switch_laser),
        .safety_lock_input(safety_lock_input), .cooler_overcurrent(cflt[0]),
        .cooler_short(cflt[1]), .cooler_overheat(cflt[2]), .laser_current_trip(trip),
        .jumper_cur_connector(j_cur), .jumper_temp_connector(j_tmp),
        .thermistor_lock_input(therm), .cooler_run(cooler_run), .laser_drive(laser_drive),
        .laser_softstart(laser_softstart), .cooler_fault(cooler_fault),
        .emitter_overcurrent_flag(eoc), .output_shunt(shunt), .red_led(red),
        .yellow_led(yellow), .cur_src_sel(cur_src), .cooler_setpoint_src(tmp_src),
        .cooler_current_limit(ilim));

    // Expected source code from the internal bit and the jumper
    function automatic logic [1:0] src(input logic intl, input logic jmp);
        return intl ? 2'h2 : {1'b0, jmp};
    endfunction : src

    // Expected pins from {cooler, drive, soft, cfault, trip, yellow}
    function automatic logic [27:0] ex(input logic [5:0] v);
        return {v[5:2], v[1], v[1], v[1], v[0], src(ctl[0], j_cur), src(ctl[1], j_tmp),
            lim_e};
    endfunction : ex

    task automatic fail(input string m);
        errors++;
        $display("ERROR %0t %s", $time, m);
    endtask : fail

    task automatic cmp_rd(input logic [32:0] e);
        tests_run++;
        if ({pslverr, prdata} !== e) fail("read data mismatch");
    endtask : cmp_rd

    task automatic cmp_pins(input logic [27:0] e);
        tests_run++;
        if ({cooler_run, laser_drive, laser_softstart, cooler_fault, eoc, shunt, red, yellow,
            cur_src, tmp_src, ilim} !== e) fail("output pins mismatch");
    endtask : cmp_pins

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
    endtask : settle

    task automatic chk(input logic [5:0] v);
        pinq.push_back(ex(v));
        snap <= 1'b1;
        @(posedge pclk);
        snap <= 1'b0;
        @(posedge pclk);
    endtask : chk

    // One APB transfer; a read notes its expected {pslverr, prdata}
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [32:0] e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w) rdq.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 50) fail("no pready");
        if (w && a == 8'h00) ctl = d[2:0];
        if (w && a == 8'h10) lim_e = d[15:0];
    endtask : apb

    task automatic rst;
        presetn <= 1'b0;
        ctl = 3'h0;
        lim_e = 16'h07D0;
        settle(2);
        presetn <= 1'b1;
    endtask : rst

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : test_done

    // Watcher: takes the oldest note whenever a result shows
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) cmp_rd(rdq.pop_front());
        if (snap) cmp_pins(pinq.pop_front());
    end

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge pclk);
        fail("timeout");
        test_done();
    end

    // Main sequence
    initial begin
        logic [31:0] r;
        settle(2);
        presetn <= 1'b1;
        nv_clear_n <= 1'b1;
        apb(1'b0, 8'h00, 32'h0, 33'h0);
        apb(1'b0, 8'h10, 32'h0, {1'b0, 32'h000007D0});
        settle(6);
        chk(6'h00);
        want <= 5'b00100;
        settle(6);
        chk(6'h20);
        want <= 5'b00001;
        settle(6);
        chk(6'h20);
        want <= 5'b01000;
        settle(8);
        chk(6'h18);
        settle(SC);
        chk(6'h10);
        want <= 5'b10011;
        settle(8);
        chk(6'h01);
        apb(1'b0, 8'h04, 32'h0, {1'b0, 32'h000000A0});
        apb(1'b1, 8'h00, 32'h4, 33'h0);
        settle(8);
        chk(6'h38);
        apb(1'b1, 8'h00, 32'h0, 33'h0);
        settle(6);
        chk(6'h01);
        want <= 5'b00000;
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, 8'h00, {30'h0, i[1:0]}, 33'h0);
            j_cur <= i[2];
            j_tmp <= i[3];
            settle(5);
            chk(6'h00);
        end
        apb(1'b1, 8'h08, 32'h02000100, 33'h0);
        therm <= 16'h0300;
        want <= 5'b01000;
        settle(8);
        chk(6'h00);
        therm <= 16'h0150;
        settle(8);
        chk(6'h18);
        apb(1'b0, 8'h0C, 32'h0, {1'b0, 32'h00000150});
        want <= 5'b00000;
        rst();
        apb(1'b0, 8'h08, 32'h0, {1'b0, 32'h02000100});
        r = $random(seed);
        apb(1'b1, 8'h10, {16'h0, r[15:0]}, 33'h0);
        apb(1'b0, 8'h10, 32'h0, {17'h0, r[15:0]});
        apb(1'b0, 8'h14, 32'h0, {1'b1, 32'h0});
        want <= 5'b01000;
        settle(8);
        trip <= 1'b1;
        settle(3);
        trip <= 1'b0;
        settle(6);
        chk(6'h02);
        want <= 5'b00000;
        settle(6);
        want <= 5'b01000;
        settle(8);
        chk(6'h02);
        for (int k = 0; k < 3; k++) begin
            want <= 5'b00000;
            rst();
            settle(4);
            want <= 5'b01001;
            settle(8);
            chk(6'h38);
            cflt <= 3'h1 << k;
            settle(3);
            cflt <= 3'h0;
            settle(6);
            chk(6'h04);
            want <= 5'b00000;
            settle(6);
            want <= 5'b01001;
            settle(8);
            chk(6'h04);
        end
        test_done();
    end
endmodule : tb

//--- src/ltep_apb_regs.sv
`timescale 1ns/100ps
`include "ltep_regs.svh"

module ltep_apb_regs import ltep_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic nv_clear_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [`LTEP_ST_W-1:0] status,
    input wire logic [15:0] therm_code,
    output logic [`LTEP_CTRL_W-1:0] ctrl,
    output logic [15:0] limit_lo,
    output logic [15:0] limit_hi,
    output logic [15:0] cooler_current_limit
);

    typedef struct packed {
        logic [`LTEP_CTRL_W-1:0] ctrl;
        logic [15:0] ilim;
        logic [31:0] rdata;
    } ltep_reg_s;

    typedef struct packed {
        logic [15:0] lo;
        logic [15:0] hi;
    } ltep_nv_s;

    ltep_reg_s r_q;
    ltep_reg_s r_d;
    ltep_nv_s nv_q;
    ltep_nv_s nv_d;
    logic hit;
    logic wr;

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == `LTEP_CTRL_OFF) || (a == `LTEP_STATUS_OFF) ||
                   (a == `LTEP_LIMIT_OFF) || (a == `LTEP_THERM_OFF) ||
                   (a == `LTEP_ILIM_OFF);
    endfunction : addr_hit

    // Zero-wait slave; unmapped addresses answer with an error
    assign hit = addr_hit(paddr);
    assign wr = psel && penable && pwrite && hit;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;

    // Writes in the access phase, read data captured in the setup phase
    always_comb begin
        r_d = r_q;
        nv_d = nv_q;
        if (wr && paddr == `LTEP_CTRL_OFF) begin
            r_d.ctrl = pwdata[`LTEP_CTRL_W-1:0];
        end else if (wr && paddr == `LTEP_LIMIT_OFF) begin
            nv_d.lo = pwdata[`LTEP_LIM_LO_LSB +: 16];
            nv_d.hi = pwdata[`LTEP_LIM_HI_LSB +: 16];
        end else if (wr && paddr == `LTEP_ILIM_OFF) begin
            r_d.ilim = pwdata[15:0];
        end
        if (psel && !penable) begin
            if (paddr == `LTEP_CTRL_OFF) begin
                r_d.rdata = {29'h0, r_q.ctrl};
            end else if (paddr == `LTEP_STATUS_OFF) begin
                r_d.rdata = {24'h0, status};
            end else if (paddr == `LTEP_LIMIT_OFF) begin
                r_d.rdata = {nv_q.hi, nv_q.lo};
            end else if (paddr == `LTEP_THERM_OFF) begin
                r_d.rdata = {16'h0, therm_code};
            end else if (paddr == `LTEP_ILIM_OFF) begin
                r_d.rdata = {16'h0, r_q.ilim};
            end else begin
                r_d.rdata = 32'h0;
            end
        end
    end

    // Control registers restart with the device
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r_q <= {`LTEP_CTRL_RST, `LTEP_ILIM_RST, 32'h0};
        end else begin
            r_q <= r_d;
        end
    end

    // Thermistor limits survive a device restart; only a storage clear resets them
    always_ff @(posedge pclk or negedge nv_clear_n) begin
        if (!nv_clear_n) begin
            nv_q <= {`LTEP_LIM_LO_RST, `LTEP_LIM_HI_RST};
        end else begin
            nv_q <= nv_d;
        end
    end

    assign prdata = r_q.rdata;
    assign ctrl = r_q.ctrl;
    assign limit_lo = nv_q.lo;
    assign limit_hi = nv_q.hi;
    assign cooler_current_limit = r_q.ilim;

endmodule : ltep_apb_regs

//--- src/ltep_pkg.sv
package ltep_pkg;

    // Laser driver sequence
    typedef enum logic [1:0] {
        LAS_OFF,
        LAS_SOFT,
        LAS_ON
    } ltep_laser_e;

    // Setpoint source
    typedef enum logic [1:0] {
        SRC_POT,
        SRC_CONNECTOR,
        SRC_DIGITAL
    } ltep_src_e;

    // Control state of the protection logic
    typedef struct packed {
        ltep_laser_e lstate;
        logic [15:0] cnt;
        logic [1:0] warm;
        logic cool_armed;
        logic las_armed;
        logic cool_fault;
        logic oc_latch;
        logic cool_run;
        logic locked;
        logic therm_bad;
        ltep_src_e cur_sel;
        ltep_src_e temp_sel;
    } ltep_ctl_s;

endpackage : ltep_pkg

//--- src/ltep_regs.svh
`ifndef LTEP_REGS_SVH
`define LTEP_REGS_SVH

// Register byte offsets
`define LTEP_CTRL_OFF 8'h00
`define LTEP_STATUS_OFF 8'h04
`define LTEP_LIMIT_OFF 8'h08
`define LTEP_THERM_OFF 8'h0C
`define LTEP_ILIM_OFF 8'h10

// Control register fields
`define LTEP_CTRL_CUR_INT 0
`define LTEP_CTRL_TEMP_INT 1
`define LTEP_CTRL_DENY_LOCK 2
`define LTEP_CTRL_W 3
`define LTEP_CTRL_RST 3'h0

// Status register fields
`define LTEP_ST_COOL_RUN 0
`define LTEP_ST_LASER_ON 1
`define LTEP_ST_SOFT 2
`define LTEP_ST_COOL_FAULT 3
`define LTEP_ST_OC_LATCH 4
`define LTEP_ST_LOCKED 5
`define LTEP_ST_THERM_BAD 6
`define LTEP_ST_LAS_ARMED 7
`define LTEP_ST_W 8

// Limit register layout and defaults
`define LTEP_LIM_LO_LSB 0
`define LTEP_LIM_HI_LSB 16
`define LTEP_LIM_LO_RST 16'h0000
`define LTEP_LIM_HI_RST 16'hFFFF

// Cooler current limit in mA, 2 A at reset
`define LTEP_ILIM_RST 16'h07D0

// Timing
`define LTEP_CLK_NS 10
`define LTEP_SOFT_NS 10000
`define LTEP_SOFT_CYC (`LTEP_SOFT_NS / `LTEP_CLK_NS)
// Edges after reset until the synchronised inputs show the pins
`define LTEP_WARM_CYC 2'h2

// Synchronised input positions
`define LTEP_IN_COOL_EN 0
`define LTEP_IN_LAS_EN 1
`define LTEP_IN_SW_COOL 2
`define LTEP_IN_SW_LAS 3
`define LTEP_IN_LOCK_OPEN 4
`define LTEP_IN_COOL_OC 5
`define LTEP_IN_COOL_SHORT 6
`define LTEP_IN_COOL_HOT 7
`define LTEP_IN_LAS_TRIP 8
`define LTEP_IN_JMP_CUR 9
`define LTEP_IN_JMP_TEMP 10
`define LTEP_IN_W 11

`endif

//--- src/ltep_sync.sv
`timescale 1ns/100ps

module ltep_sync import ltep_pkg::*; #(
    parameter int W = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ltep_sync_s;

    ltep_sync_s st_q;
    ltep_sync_s st_d;

    // Two stages; the first stage feeds only the second
    always_comb begin
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.s2;

endmodule : ltep_sync

//--- src/ltep_top.sv
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "ltep_regs.svh"

module ltep_top import ltep_pkg::*; #(
    parameter int SOFT_CYC = `LTEP_SOFT_CYC,
    parameter int TW = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic nv_clear_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cooler_enable,
    input wire logic laser_enable,
    input wire logic switch_cooler,
    input wire logic switch_laser,
    input wire logic safety_lock_input,
    input wire logic cooler_overcurrent,
    input wire logic cooler_short,
    input wire logic cooler_overheat,
    input wire logic laser_current_trip,
    input wire logic jumper_cur_connector,
    input wire logic jumper_temp_connector,
    input wire logic [TW-1:0] thermistor_lock_input,
    output logic cooler_run,
    output logic laser_drive,
    output logic laser_softstart,
    output logic cooler_fault,
    output logic emitter_overcurrent_flag,
    output logic output_shunt,
    output logic red_led,
    output logic yellow_led,
    output logic [1:0] cur_src_sel,
    output logic [1:0] cooler_setpoint_src,
    output logic [15:0] cooler_current_limit
);

    localparam logic [15:0] SOFT_LAST = 16'(SOFT_CYC - 1);

    ltep_ctl_s ctl_q;
    ltep_ctl_s ctl_d;
    logic [`LTEP_IN_W-1:0] raw_in;
    logic [`LTEP_IN_W-1:0] s_in;
    logic [`LTEP_CTRL_W-1:0] ctrl;
    logic [15:0] limit_lo;
    logic [15:0] limit_hi;
    logic [`LTEP_ST_W-1:0] status;
    logic cool_req;
    logic las_req;
    logic locked;
    logic therm_bad;
    logic cool_err;
    logic blocked;

    // Pick the source for one setpoint quantity
    function automatic ltep_src_e pick_src(input logic internal, input logic jumper_ext);
        if (internal) begin
            pick_src = SRC_DIGITAL;
        end else if (jumper_ext) begin
            pick_src = SRC_CONNECTOR;
        end else begin
            pick_src = SRC_POT;
        end
    endfunction : pick_src

    // Gather the pins that cross into the clock domain
    always_comb begin
        raw_in = '0;
        raw_in[`LTEP_IN_COOL_EN] = cooler_enable;
        raw_in[`LTEP_IN_LAS_EN] = laser_enable;
        raw_in[`LTEP_IN_SW_COOL] = switch_cooler;
        raw_in[`LTEP_IN_SW_LAS] = switch_laser;
        raw_in[`LTEP_IN_LOCK_OPEN] = safety_lock_input;
        raw_in[`LTEP_IN_COOL_OC] = cooler_overcurrent;
        raw_in[`LTEP_IN_COOL_SHORT] = cooler_short;
        raw_in[`LTEP_IN_COOL_HOT] = cooler_overheat;
        raw_in[`LTEP_IN_LAS_TRIP] = laser_current_trip;
        raw_in[`LTEP_IN_JMP_CUR] = jumper_cur_connector;
        raw_in[`LTEP_IN_JMP_TEMP] = jumper_temp_connector;
    end

    // Two-stage synchroniser for all control pins
    ltep_sync #(.W(`LTEP_IN_W)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(raw_in),
        .q(s_in)
    );

    // Register file on the APB bus
    ltep_apb_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .nv_clear_n(nv_clear_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .status(status),
        .therm_code(thermistor_lock_input),
        .ctrl(ctrl),
        .limit_lo(limit_lo),
        .limit_hi(limit_hi),
        .cooler_current_limit(cooler_current_limit)
    );

    // Requests: connector inputs and board switches are equivalent
    assign cool_req = s_in[`LTEP_IN_COOL_EN] | s_in[`LTEP_IN_SW_COOL];
    assign las_req = s_in[`LTEP_IN_LAS_EN] | s_in[`LTEP_IN_SW_LAS];

    // Lock conditions
    assign locked = s_in[`LTEP_IN_LOCK_OPEN] && !ctrl[`LTEP_CTRL_DENY_LOCK];
    assign therm_bad = (thermistor_lock_input > limit_hi) ||
                       (thermistor_lock_input < limit_lo);
    assign cool_err = s_in[`LTEP_IN_COOL_OC] | s_in[`LTEP_IN_COOL_SHORT] |
                      s_in[`LTEP_IN_COOL_HOT];
    // Built from raw conditions so it does not loop through the next-state copy
    assign blocked = ctl_q.cool_fault || cool_err || ctl_q.oc_latch ||
                     s_in[`LTEP_IN_LAS_TRIP] || locked || therm_bad;

    // Next-state logic of the protection sequencer
    always_comb begin
        ctl_d = ctl_q;
        // Synchroniser resets to zero; trust a low request only once it has filled
        if (ctl_q.warm != `LTEP_WARM_CYC) begin
            ctl_d.warm = ctl_q.warm + 2'h1;
        end
        // A request must be seen low once before it can start anything
        if (!cool_req && ctl_q.warm == `LTEP_WARM_CYC) begin
            ctl_d.cool_armed = 1'b1;
        end
        if (!las_req && ctl_q.warm == `LTEP_WARM_CYC) begin
            ctl_d.las_armed = 1'b1;
        end
        // Faults latch until reset; nothing else clears them
        ctl_d.cool_fault = ctl_q.cool_fault | cool_err;
        ctl_d.oc_latch = ctl_q.oc_latch | s_in[`LTEP_IN_LAS_TRIP];
        ctl_d.locked = locked;
        ctl_d.therm_bad = therm_bad;
        // Cooler follows its request while enabled, unlocked and fault-free
        ctl_d.cool_run = ctl_q.cool_armed && cool_req && !locked &&
                         !ctl_d.cool_fault;
        // Setpoint sources
        ctl_d.cur_sel = pick_src(ctrl[`LTEP_CTRL_CUR_INT],
                                 s_in[`LTEP_IN_JMP_CUR]);
        ctl_d.temp_sel = pick_src(ctrl[`LTEP_CTRL_TEMP_INT],
                                  s_in[`LTEP_IN_JMP_TEMP]);
        // Laser sequence
        case (ctl_q.lstate)
            LAS_OFF: begin
                ctl_d.cnt = 16'h0000;
                if (ctl_q.las_armed && las_req && !blocked) begin
                    ctl_d.lstate = LAS_SOFT;
                end
            end
            LAS_SOFT: begin
                if (!las_req || blocked) begin
                    ctl_d.lstate = LAS_OFF;
                    ctl_d.cnt = 16'h0000;
                end else if (ctl_q.cnt == SOFT_LAST) begin
                    ctl_d.lstate = LAS_ON;
                    ctl_d.cnt = 16'h0000;
                end else begin
                    ctl_d.cnt = ctl_q.cnt + 16'h0001;
                end
            end
            LAS_ON: begin
                if (!las_req || blocked) begin
                    ctl_d.lstate = LAS_OFF;
                end
            end
            default: begin
                ctl_d.lstate = LAS_OFF;
            end
        endcase
    end

    // State register; reset gives potentiometer sources and honoured interlock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= '{lstate: LAS_OFF, cnt: 16'h0000, warm: 2'h0, cool_armed: 1'b0,
                       las_armed: 1'b0, cool_fault: 1'b0, oc_latch: 1'b0,
                       cool_run: 1'b0, locked: 1'b0, therm_bad: 1'b0,
                       cur_sel: SRC_POT, temp_sel: SRC_POT};
        end else begin
            ctl_q <= ctl_d;
        end
    end

    // Outputs straight from state flops
    assign cooler_run = ctl_q.cool_run;
    assign laser_drive = (ctl_q.lstate != LAS_OFF);
    assign laser_softstart = (ctl_q.lstate == LAS_SOFT);
    assign cooler_fault = ctl_q.cool_fault;
    assign emitter_overcurrent_flag = ctl_q.oc_latch;
    assign output_shunt = ctl_q.oc_latch;
    assign red_led = ctl_q.oc_latch;
    assign yellow_led = ctl_q.locked;
    assign cur_src_sel = ctl_q.cur_sel;
    assign cooler_setpoint_src = ctl_q.temp_sel;

    // Status word for software
    always_comb begin
        status = '0;
        status[`LTEP_ST_COOL_RUN] = ctl_q.cool_run;
        status[`LTEP_ST_LASER_ON] = laser_drive;
        status[`LTEP_ST_SOFT] = laser_softstart;
        status[`LTEP_ST_COOL_FAULT] = ctl_q.cool_fault;
        status[`LTEP_ST_OC_LATCH] = ctl_q.oc_latch;
        status[`LTEP_ST_LOCKED] = ctl_q.locked;
        status[`LTEP_ST_THERM_BAD] = ctl_q.therm_bad;
        status[`LTEP_ST_LAS_ARMED] = ctl_q.las_armed;
    end

    // Checks on the protection behaviour
    a_cool_follow: assert property (@(posedge pclk) disable iff (!presetn)
        !cool_req |=> !cooler_run)
        else $error("cooler runs without request");

    a_soft_first: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(laser_drive) |-> laser_softstart)
        else $error("laser started without soft-start");

    a_soft_length: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(laser_softstart) && laser_drive |-> $past(ctl_q.cnt) == SOFT_LAST)
        else $error("soft-start length wrong");

    a_cool_fault_set: assert property (@(posedge pclk) disable iff (!presetn)
        cool_err |=> cooler_fault)
        else $error("cooler fault not raised");

    a_cool_fault_hold: assert property (@(posedge pclk) disable iff (!presetn)
        cooler_fault |=> cooler_fault && !laser_drive)
        else $error("cooler fault cleared or laser running");

    a_trip_shunt: assert property (@(posedge pclk) disable iff (!presetn)
        s_in[`LTEP_IN_LAS_TRIP] |=> output_shunt && red_led && !laser_drive)
        else $error("trip did not shunt and stop laser");

    a_flag_shunt: assert property (@(posedge pclk) disable iff (!presetn)
        emitter_overcurrent_flag == output_shunt)
        else $error("overcurrent flag differs from shunt");

    a_trip_no_restart: assert property (@(posedge pclk) disable iff (!presetn)
        emitter_overcurrent_flag |=> emitter_overcurrent_flag && !laser_drive)
        else $error("laser restarted after trip");

    a_therm_block: assert property (@(posedge pclk) disable iff (!presetn)
        therm_bad |=> !laser_drive)
        else $error("laser runs outside thermistor window");

    a_src_digital: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl[`LTEP_CTRL_CUR_INT] |=> cur_src_sel == SRC_DIGITAL)
        else $error("digital current source not selected");

    a_lock_off: assert property (@(posedge pclk) disable iff (!presetn)
        yellow_led |-> !cooler_run && !laser_drive)
        else $error("output active while locked");

    a_unarmed_off: assert property (@(posedge pclk) disable iff (!presetn)
        !ctl_q.las_armed |-> !laser_drive)
        else $error("laser on without fresh enable");

    a_warm_unarmed: assert property (@(posedge pclk) disable iff (!presetn)
        ctl_q.warm != `LTEP_WARM_CYC |-> !ctl_q.las_armed && !ctl_q.cool_armed)
        else $error("request armed before inputs settled");

    a_fault_cool_off: assert property (@(posedge pclk) disable iff (!presetn)
        cooler_fault |-> !cooler_run)
        else $error("cooler runs with latched fault");

    a_src_connector: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl[`LTEP_CTRL_TEMP_INT] && s_in[`LTEP_IN_JMP_TEMP] |=>
        cooler_setpoint_src == SRC_CONNECTOR)
        else $error("connector temperature source not selected");

    a_yellow_lock: assert property (@(posedge pclk) disable iff (!presetn)
        locked |=> yellow_led)
        else $error("yellow indicator off while locked");

endmodule : ltep_top
